/* cg_ctl_regs.svh */
// Purpose: Register addresses, bit positions, codes and timing constants.
// Assumes: 128 byte register space, two output dividers, 50 MHz clk_sys.
// Notes: Included by every design file of the clock generator control except the package.
`ifndef CG_CTL_REGS_SVH
`define CG_CTL_REGS_SVH
`define NREG 128
`define NBANK 4
`define NOUT 2
`define A_CFG 7'h00
`define B_DEF_CHOICE 7
`define B_ADDR_SEL 0
`define A_GATE 7'h10
`define B_POL 1
`define B_FUNC 3
`define A_REFSEL 7'h13
`define B_PRIM 1
`define B_SM_HI 7
`define A_OUTEN 7'h68
`define B_PATH0 0
`define B_HON0 4
`define A_OTP 7'h72
`define B_SAVE 3
`define B_RESTORE 0
`define B_SYNC 5
`define B_SYNC_DIS 6
`define A_DIV0 7'h2d
`define DIV_STRIDE 7'h10
`define CMD_SAVE 8'h08
`define CMD_RESTORE 8'h01
`define SLV_ADDR_DEF 7'h6a
`define SLV_ADDR_ALT 7'h68
`define SW_GAP 4'h4
`define SYNC_RST_US 300
`define CLK_MHZ 50
`define SYNC_RST_CYC (`SYNC_RST_US * `CLK_MHZ)
`define POR_SETTLE 2'h3
`endif

/* cg_ctl_pkg.sv */
// Purpose: Shared types of the clock generator control.
// Assumes: Constants come from cg_ctl_regs.svh.
// Notes: Structs carry the serial port events between modules.
package cg_ctl_pkg;
	// One event word from the serial slave, valid for one cycle.
	typedef struct packed {
		logic start;
		logic stop;
		logic byte_ok;
		logic rd_load;
		logic rw;
		logic [7:0] idx;
		logic [7:0] data;
	} i2c_ev_t;
	// Drive state of one output pair.
	typedef enum logic [3:0] {
		OM_RUN = 4'h1,
		OM_TRI = 4'h2,
		OM_PARK = 4'h4,
		OM_SHUT = 4'h8
	} out_mode_t;
	// Control sequencer states.
	typedef enum logic [3:0] {
		ST_POR = 4'h1,
		ST_LOAD = 4'h2,
		ST_RUN = 4'h4,
		ST_SAVE = 4'h8
	} ctl_state_t;
	// Serial slave states.
	typedef enum logic [4:0] {
		SL_IDLE = 5'h01,
		SL_RX = 5'h02,
		SL_ACK = 5'h04,
		SL_TX = 5'h08,
		SL_RACK = 5'h10
	} slv_state_t;
endpackage : cg_ctl_pkg

/* cg_otp_store.sv */
// Purpose: One-time-programmable store model with four banks.
// Assumes: One byte written per cycle; read is combinational.
// Notes: Cleared at reset so that a blank part restores zeros.
`timescale 1ns/1ps
`include "cg_ctl_regs.svh"
module cg_otp_store
	import cg_ctl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wr_en,
	input wire logic [8:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	// Storage of all banks, bank number in the upper address bits.
	logic [7:0] mem_ff [0:`NREG*`NBANK-1];
	logic [7:0] nxt_byte;
	// Next value of the addressed cell.
	always_comb
	begin
		nxt_byte = wr_en ? wr_data : mem_ff[addr];
	end
	// Register the cell; reset blanks the whole array.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `NREG*`NBANK; i++)
				mem_ff[i] <= 8'h00;
		end
		else
		begin
			mem_ff[addr] <= nxt_byte;
		end
	end
	assign rd_data = mem_ff[addr];
endmodule : cg_otp_store

/* cg_i2c_slave.sv */
// Purpose: Oversampled serial slave producing byte events.
// Assumes: SCL and SDA come from pins; clk_sys is far faster than SCL.
// Notes: SDA is open drain; sda_oe high pulls the line low.
`timescale 1ns/1ps
`include "cg_ctl_regs.svh"
module cg_i2c_slave
	import cg_ctl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic [6:0] dev_addr,
	input wire logic busy,
	input wire logic [7:0] rd_data,
	output i2c_ev_t ev,
	output logic sda_oe
);
	logic [2:0] scl_ff, sda_ff, nxt_scl, nxt_sda; // Stage 0 is read by stage 1 only.
	slv_state_t st_ff, nxt_st;
	logic [7:0] sh_ff, nxt_sh;
	logic [2:0] bit_ff, nxt_bit;
	logic [7:0] idx_ff, nxt_idx;
	logic ack_ff, nxt_ack, rw_ff, nxt_rw, oe_ff, nxt_oe;
	i2c_ev_t nxt_ev;
	logic rise, fall, start, stop;
	// Edge and condition detection on the second and third stages.
	always_comb
	begin
		nxt_scl = {scl_ff[1:0], scl_in};
		nxt_sda = {sda_ff[1:0], sda_in};
		rise = scl_ff[1] & ~scl_ff[2];
		fall = ~scl_ff[1] & scl_ff[2];
		start = scl_ff[1] & scl_ff[2] & sda_ff[2] & ~sda_ff[1];
		stop = scl_ff[1] & scl_ff[2] & ~sda_ff[2] & sda_ff[1];
	end
	// Bit engine: shift in on rising edges, change SDA on falling edges.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_sh = sh_ff;
		nxt_bit = bit_ff;
		nxt_idx = idx_ff;
		nxt_ack = ack_ff;
		nxt_rw = rw_ff;
		nxt_oe = oe_ff;
		nxt_ev = '0;
		nxt_ev.rw = rw_ff;
		nxt_ev.idx = idx_ff;
		if (start)
		begin
			// A repeated start restarts the byte count too.
			nxt_st = SL_RX;
			nxt_bit = 3'h0;
			nxt_idx = 8'h00;
			nxt_oe = 1'b0;
			nxt_ev.start = 1'b1;
		end
		else if (stop)
		begin
			nxt_st = SL_IDLE;
			nxt_oe = 1'b0;
			nxt_ev.stop = 1'b1;
		end
		else
		begin
			case (st_ff)
				SL_RX:
				begin
					if (rise)
					begin
						nxt_sh = {sh_ff[6:0], sda_ff[1]};
						nxt_bit = bit_ff + 3'h1;
						if (bit_ff == 3'h7)
						begin
							nxt_st = SL_ACK;
							nxt_ev.byte_ok = 1'b1;
							nxt_ev.data = {sh_ff[6:0], sda_ff[1]};
							if (idx_ff == 8'h00)
							begin
								// Silence while busy keeps the bus held off.
								nxt_ack = (sh_ff[6:0] == dev_addr) & ~busy;
								nxt_rw = sda_ff[1];
							end
							else
								nxt_ack = 1'b1;
						end
					end
				end
				SL_ACK:
				begin
					if (fall)
					begin
						// First falling edge starts the ack slot, second ends it.
						if (!oe_ff && ack_ff)
							nxt_oe = 1'b1;
						else
						begin
							nxt_oe = 1'b0;
							nxt_idx = (idx_ff == 8'hff) ? idx_ff : idx_ff + 8'h01;
							if (!ack_ff)
								nxt_st = SL_IDLE;
							else if (rw_ff)
							begin
								nxt_st = SL_TX;
								nxt_sh = rd_data;
								nxt_oe = ~rd_data[7];
								nxt_ev.rd_load = 1'b1;
							end
							else
								nxt_st = SL_RX;
						end
					end
				end
				SL_TX:
				begin
					if (fall)
					begin
						nxt_bit = bit_ff + 3'h1;
						nxt_sh = {sh_ff[6:0], 1'b0};
						nxt_oe = ~sh_ff[6];
						if (bit_ff == 3'h7)
						begin
							nxt_st = SL_RACK;
							nxt_oe = 1'b0;
						end
					end
				end
				SL_RACK:
				begin
					// Master ack low means another byte is wanted.
					if (rise)
						nxt_ack = ~sda_ff[1];
					if (fall)
					begin
						if (ack_ff)
						begin
							nxt_st = SL_TX;
							nxt_sh = rd_data;
							nxt_oe = ~rd_data[7];
							nxt_ev.rd_load = 1'b1;
						end
						else
							nxt_st = SL_IDLE;
					end
				end
				default:
				begin
					nxt_st = SL_IDLE;
				end
			endcase
		end
	end
	// Registers of the slave; idle lines read as high.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			scl_ff <= 3'h7;
			sda_ff <= 3'h7;
			st_ff <= SL_IDLE;
			sh_ff <= 8'h00;
			bit_ff <= 3'h0;
			idx_ff <= 8'h00;
			ack_ff <= 1'b0;
			rw_ff <= 1'b0;
			oe_ff <= 1'b0;
			ev <= '0;
		end
		else
		begin
			scl_ff <= nxt_scl;
			sda_ff <= nxt_sda;
			st_ff <= nxt_st;
			sh_ff <= nxt_sh;
			bit_ff <= nxt_bit;
			idx_ff <= nxt_idx;
			ack_ff <= nxt_ack;
			rw_ff <= nxt_rw;
			oe_ff <= nxt_oe;
			ev <= nxt_ev;
		end
	end
	assign sda_oe = oe_ff;
endmodule : cg_i2c_slave

/* clock_gen_config_control.sv */
// Purpose: Configuration control of a programmable clock generator.
// Assumes: sys_rst is the internal power-on reset; pins are asynchronous.
// Notes: Registers are a 128 byte array reached through the serial slave.
`timescale 1ns/1ps
`include "cg_ctl_regs.svh"
module clock_gen_config_control
	import cg_ctl_pkg::*;
#(
	parameter int unsigned SYNC_RST_CYCLES = `SYNC_RST_CYC
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic input_select_pin,
	input wire logic shutdown_or_gate_pin,
	input wire logic config_select_pin_lo,
	input wire logic config_select_pin_hi,
	input wire logic interface_strap_pin,
	output logic ref_is_external,
	output logic ref_switch_quiet,
	output logic manual_mode,
	output logic pll_shutdown,
	output out_mode_t [`NOUT-1:0] out_mode,
	output logic div_sync_reset,
	output logic [`NOUT-1:0][11:0] div_int,
	output logic [`NOUT-1:0][23:0] div_frac,
	output logic [`NOUT-1:0] div_int_only,
	output logic [`NOUT-1:0][4:0] skew_step,
	output logic config_ready,
	output logic otp_busy
);
	// Drive mode of one output from the gate pin controls.
	function automatic out_mode_t gate_mode(input logic func, input logic pol,
		input logic path, input logic honour, input logic pin);
		logic asserted;
		asserted = pin ^ ~pol;
		if (func && asserted)
			gate_mode = OM_SHUT;
		else if (!path)
			gate_mode = OM_TRI;
		else if (honour && asserted && !func)
			gate_mode = OM_PARK;
		else
			gate_mode = OM_RUN;
	endfunction : gate_mode

	// Register byte of output n at a given offset inside its divider block.
	function automatic logic [6:0] div_addr(input int n, input logic [6:0] off);
		div_addr = `A_DIV0 + 7'(n) * `DIV_STRIDE + off;
	endfunction : div_addr

	logic [7:0] regs_ff [0:`NREG-1]; // Programming registers.
	logic [7:0] nxt_regs [0:`NREG-1];
	logic [7:0] wbuf_ff [0:`NREG-1]; // Block write staging.
	logic [7:0] nxt_wbuf [0:`NREG-1];
	logic [4:0] pins_s1_ff, pins_s2_ff; // Stage one read by stage two only.
	ctl_state_t st_ff, nxt_st;
	logic [6:0] ptr_ff, nxt_ptr; // Register pointer of the current access.
	logic [6:0] wstart_ff, nxt_wstart;
	logic [7:0] wcnt_ff, nxt_wcnt; // Bytes staged in this block write.
	logic [7:0] cmd_ff, nxt_cmd; // Second byte, a command if nothing follows.
	logic [7:0] last_idx_ff, nxt_last_idx;
	logic wr_tr_ff, nxt_wr_tr; // Current transfer is a write to this slave.
	logic [6:0] cnt_ff, nxt_cnt; // Byte counter of load and save.
	logic [1:0] bank_ff, nxt_bank;
	logic strap_ff, nxt_strap; // Strap level taken after reset release.
	logic por_ff, nxt_por; // First load after power-up.
	logic pinload_ff, nxt_pinload; // Load caused by a select pin change.
	logic [1:0] settle_ff, nxt_settle;
	logic [15:0] sync_ff, nxt_sync;
	logic ref_ff, nxt_ref, quiet_ff, nxt_quiet;
	logic [3:0] gap_ff, nxt_gap;
	out_mode_t [`NOUT-1:0] mode_ff, nxt_mode;
	logic [7:0] otp_rd;
	logic otp_we;
	logic [8:0] otp_addr;
	logic [6:0] slv_addr;
	logic [1:0] sel_pins;
	logic want_ext, sync_go, in_run;
	i2c_ev_t ev;

	// Serial slave; it does not acknowledge its address while the sequencer is not running.
	cg_i2c_slave u_slave (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.dev_addr(slv_addr),
		.busy(~in_run),
		.rd_data(regs_ff[ptr_ff]),
		.ev(ev),
		.sda_oe(sda_oe)
	);

	// Nonvolatile store; the sequencer walks it one byte per cycle.
	cg_otp_store u_otp (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.wr_en(otp_we),
		.addr(otp_addr),
		.wr_data(regs_ff[cnt_ff]),
		.rd_data(otp_rd)
	);

	assign in_run = (st_ff == ST_RUN);
	assign otp_we = (st_ff == ST_SAVE);
	assign otp_addr = {bank_ff, cnt_ff};
	assign sel_pins = pins_s2_ff[3:2];
	assign slv_addr = regs_ff[`A_CFG][`B_ADDR_SEL] ? `SLV_ADDR_ALT : `SLV_ADDR_DEF;
	assign sda_out = 1'b0;

	// Sequencer, serial register access, OTP walks and sync reset timer.
	always_comb
	begin
		nxt_regs = regs_ff;
		nxt_wbuf = wbuf_ff;
		nxt_st = st_ff;
		nxt_ptr = ptr_ff;
		nxt_wstart = wstart_ff;
		nxt_wcnt = wcnt_ff;
		nxt_cmd = cmd_ff;
		nxt_last_idx = last_idx_ff;
		nxt_wr_tr = wr_tr_ff;
		nxt_cnt = cnt_ff;
		nxt_bank = bank_ff;
		nxt_strap = strap_ff;
		nxt_por = por_ff;
		nxt_pinload = pinload_ff;
		nxt_settle = settle_ff;
		sync_go = 1'b0;
		nxt_sync = (sync_ff != 16'h0000) ? sync_ff - 16'h0001 : sync_ff;
		case (st_ff)
			ST_POR:
			begin
				// Let the pin synchronisers fill before the strap is taken.
				nxt_settle = settle_ff + 2'h1;
				if (settle_ff == `POR_SETTLE)
				begin
					nxt_strap = pins_s2_ff[4];
					nxt_bank = pins_s2_ff[4] ? pins_s2_ff[3:2] : 2'h0;
					nxt_cnt = 7'h00;
					nxt_st = ST_LOAD;
				end
			end
			ST_LOAD:
			begin
				nxt_regs[cnt_ff] = otp_rd;
				nxt_cnt = cnt_ff + 7'h01;
				if (cnt_ff == 7'(`NREG - 1))
				begin
					nxt_st = ST_RUN;
					if (!strap_ff && regs_ff[`A_CFG][`B_DEF_CHOICE])
					begin
						// Serial defaults replace configuration 0.
						for (int i = 0; i < `NREG; i++)
							nxt_regs[i] = 8'h00;
					end
					// Power-up always aligns; a pin change only if not disabled.
					if (por_ff || (pinload_ff && !regs_ff[`A_OTP][`B_SYNC_DIS]))
						sync_go = 1'b1;
					nxt_por = 1'b0;
					nxt_pinload = 1'b0;
				end
			end
			ST_SAVE:
			begin
				nxt_cnt = cnt_ff + 7'h01;
				if (cnt_ff == 7'(`NREG - 1))
					nxt_st = ST_RUN;
			end
			ST_RUN:
			begin
				if (ev.start)
				begin
					nxt_wcnt = 8'h00;
					nxt_wr_tr = 1'b0;
					nxt_last_idx = 8'h00;
				end
				if (ev.byte_ok)
				begin
					nxt_last_idx = ev.idx;
					if (ev.idx == 8'h00)
						nxt_wr_tr = (ev.data[7:1] == slv_addr) & ~ev.data[0];
					else if (wr_tr_ff && ev.idx == 8'h01)
						nxt_cmd = ev.data;
					else if (wr_tr_ff && ev.idx == 8'h02)
					begin
						nxt_ptr = ev.data[6:0];
						nxt_wstart = ev.data[6:0];
					end
					else if (wr_tr_ff && wcnt_ff < 8'(`NREG))
					begin
						nxt_wbuf[wcnt_ff[6:0]] = ev.data;
						nxt_wcnt = wcnt_ff + 8'h01;
					end
				end
				if (ev.rd_load)
					nxt_ptr = ptr_ff + 7'h01;
				if (ev.stop && wr_tr_ff)
				begin
					nxt_wr_tr = 1'b0;
					// All staged bytes land in the same cycle.
					for (int i = 0; i < `NREG; i++)
						if (8'(7'(i) - wstart_ff) < wcnt_ff)
							nxt_regs[i] = wbuf_ff[7'(7'(i) - wstart_ff)];
					nxt_cnt = 7'h00;
					if (last_idx_ff == 8'h01 && cmd_ff == `CMD_SAVE)
						nxt_st = ST_SAVE;
					else if (last_idx_ff == 8'h01 && cmd_ff == `CMD_RESTORE)
						nxt_st = ST_LOAD;
					else if (wcnt_ff != 8'h00)
					begin
						if (nxt_regs[`A_OTP][`B_SAVE])
							nxt_st = ST_SAVE;
						else if (nxt_regs[`A_OTP][`B_RESTORE])
							nxt_st = ST_LOAD;
						if (nxt_regs[`A_OTP][`B_SYNC])
							sync_go = 1'b1;
					end
					// Trigger bits clear themselves once taken.
					nxt_regs[`A_OTP][`B_SAVE] = 1'b0;
					nxt_regs[`A_OTP][`B_RESTORE] = 1'b0;
					nxt_regs[`A_OTP][`B_SYNC] = 1'b0;
				end
				else if (strap_ff && !regs_ff[`A_CFG][`B_DEF_CHOICE] && sel_pins != bank_ff)
				begin
					// Pin selected configuration change reloads the new bank.
					nxt_bank = sel_pins;
					nxt_cnt = 7'h00;
					nxt_pinload = 1'b1;
					nxt_st = ST_LOAD;
				end
			end
			default:
			begin
				nxt_st = ST_POR;
			end
		endcase
		if (sync_go)
			nxt_sync = 16'(SYNC_RST_CYCLES);
	end

	// Reference selection with a quiet gap around each select change.
	always_comb
	begin
		nxt_ref = ref_ff;
		nxt_quiet = quiet_ff;
		nxt_gap = gap_ff;
		want_ext = regs_ff[`A_REFSEL][`B_PRIM];
		if (!regs_ff[`A_REFSEL][`B_SM_HI])
			want_ext = regs_ff[`A_REFSEL][`B_PRIM] ^ pins_s2_ff[0];
		if (quiet_ff)
		begin
			// Gate off, flip halfway, gate on: no runt pulse reaches the PLL.
			nxt_gap = gap_ff + 4'h1;
			if (gap_ff == `SW_GAP)
				nxt_ref = want_ext;
			if (gap_ff == `SW_GAP + `SW_GAP)
			begin
				nxt_quiet = 1'b0;
				nxt_gap = 4'h0;
			end
		end
		else if (want_ext != ref_ff && in_run)
			nxt_quiet = 1'b1;
	end

	// Output gating from the synchronised gate pin.
	always_comb
	begin
		for (int n = 0; n < `NOUT; n++)
			nxt_mode[n] = gate_mode(regs_ff[`A_GATE][`B_FUNC], regs_ff[`A_GATE][`B_POL],
				regs_ff[`A_OUTEN][`B_PATH0 + n], regs_ff[`A_OUTEN][`B_HON0 + n],
				pins_s2_ff[1]);
	end

	// Register stage of all control state.
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `NREG; i++)
			begin
				regs_ff[i] <= 8'h00;
				wbuf_ff[i] <= 8'h00;
			end
			pins_s1_ff <= 5'h00;
			pins_s2_ff <= 5'h00;
			st_ff <= ST_POR;
			ptr_ff <= 7'h00;
			wstart_ff <= 7'h00;
			wcnt_ff <= 8'h00;
			cmd_ff <= 8'h00;
			last_idx_ff <= 8'h00;
			wr_tr_ff <= 1'b0;
			cnt_ff <= 7'h00;
			bank_ff <= 2'h0;
			strap_ff <= 1'b0;
			por_ff <= 1'b1;
			pinload_ff <= 1'b0;
			settle_ff <= 2'h0;
			sync_ff <= 16'h0000;
			ref_ff <= 1'b0;
			quiet_ff <= 1'b0;
			gap_ff <= 4'h0;
			// Element by element keeps the enum type intact.
			for (int n = 0; n < `NOUT; n++)
				mode_ff[n] <= OM_TRI;
		end
		else
		begin
			regs_ff <= nxt_regs;
			wbuf_ff <= nxt_wbuf;
			pins_s1_ff <= {interface_strap_pin, config_select_pin_hi,
				config_select_pin_lo, shutdown_or_gate_pin, input_select_pin};
			pins_s2_ff <= pins_s1_ff;
			st_ff <= nxt_st;
			ptr_ff <= nxt_ptr;
			wstart_ff <= nxt_wstart;
			wcnt_ff <= nxt_wcnt;
			cmd_ff <= nxt_cmd;
			last_idx_ff <= nxt_last_idx;
			wr_tr_ff <= nxt_wr_tr;
			cnt_ff <= nxt_cnt;
			bank_ff <= nxt_bank;
			strap_ff <= nxt_strap;
			por_ff <= nxt_por;
			pinload_ff <= nxt_pinload;
			settle_ff <= nxt_settle;
			sync_ff <= nxt_sync;
			ref_ff <= nxt_ref;
			quiet_ff <= nxt_quiet;
			gap_ff <= nxt_gap;
			mode_ff <= nxt_mode;
		end
	end

	// Divider settings straight from the register image.
	always_comb
	begin
		for (int n = 0; n < `NOUT; n++)
		begin
			div_int[n] = {regs_ff[div_addr(n, 7'h0)][3:0], regs_ff[div_addr(n, 7'h1)]};
			div_frac[n] = {regs_ff[div_addr(n, 7'h2)], regs_ff[div_addr(n, 7'h3)],
				regs_ff[div_addr(n, 7'h4)]};
			div_int_only[n] = regs_ff[div_addr(n, 7'h5)][0];
			skew_step[n] = regs_ff[div_addr(n, 7'h5)][7:3];
		end
	end

	assign ref_is_external = ref_ff;
	assign ref_switch_quiet = quiet_ff;
	assign manual_mode = ~regs_ff[`A_REFSEL][`B_SM_HI];
	assign pll_shutdown = (mode_ff[0] == OM_SHUT);
	assign out_mode = mode_ff;
	assign div_sync_reset = (sync_ff != 16'h0000);
	assign config_ready = in_run;
	assign otp_busy = ~in_run;
endmodule : clock_gen_config_control

/* clock_gen_config_control_assertions.sv */
// Purpose: Port checks of the clock generator control.
// Assumes: One clock domain; sys_rst is synchronous and active high.
// Notes: The bind below the checker attaches it to every top instance.
`timescale 1ns/1ps
`include "cg_ctl_regs.svh"
module cg_ctl_checker
	import cg_ctl_pkg::*;
#(
	parameter int unsigned SYNC_RST_CYCLES = `SYNC_RST_CYC
)
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic sda_oe,
	input wire logic ref_is_external,
	input wire logic ref_switch_quiet,
	input wire logic pll_shutdown,
	input wire out_mode_t [`NOUT-1:0] out_mode,
	input wire logic div_sync_reset,
	input wire logic config_ready,
	input wire logic otp_busy
);
	// Cycles seen so far in the current divider sync pulse.
	logic [15:0] sync_cnt_ff;
	logic [15:0] nxt_sync_cnt;
	// Count while the pulse is high, restart from zero when it is low.
	always_comb
	begin
		nxt_sync_cnt = div_sync_reset ? sync_cnt_ff + 16'h1 : 16'h0;
	end
	// Register the count; cleared by the power-on reset.
	always_ff @(posedge clk_sys)
	begin
		sync_cnt_ff <= sys_rst ? 16'h0 : nxt_sync_cnt;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Outputs stay quiet for a bounded time around a reference change.
	sequence quiet_window;
		ref_switch_quiet [*8] ##[1:4] !ref_switch_quiet;
	endsequence
	a_busy_inverse: assert property (otp_busy == !config_ready)
		else $error("busy flag is not the inverse of ready");
	a_ack_when_ready: assert property (sda_oe |-> config_ready)
		else $error("data line pulled while loading or saving");
	a_load_first: assert property ($fell(sys_rst) |-> !config_ready [*8])
		else $error("ready too soon after reset");
	a_shut_parks: assert property (pll_shutdown [*3] |->
		out_mode[0] == OM_SHUT && out_mode[1] == OM_SHUT)
		else $error("output running during shutdown");
	a_no_stray_shut: assert property (!pll_shutdown [*3] |->
		out_mode[0] != OM_SHUT && out_mode[1] != OM_SHUT)
		else $error("output shut without global shutdown");
	a_quiet_window: assert property ($rose(ref_switch_quiet) |-> quiet_window)
		else $error("quiet window of wrong length");
	a_flip_in_quiet: assert property ($changed(ref_is_external) |->
		ref_switch_quiet && $past(ref_switch_quiet))
		else $error("reference moved outside the quiet window");
	a_sync_length: assert property ($fell(div_sync_reset) |->
		sync_cnt_ff == 16'(SYNC_RST_CYCLES))
		else $error("divider sync pulse of wrong length");
	// Only the power-up load must align; a restore or save need not.
	a_ready_sync: assert property ($fell(sys_rst) |-> ##[130:140] div_sync_reset)
		else $error("no divider sync after start-up");
endmodule : cg_ctl_checker
bind clock_gen_config_control cg_ctl_checker #(.SYNC_RST_CYCLES(SYNC_RST_CYCLES)) chk_i (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.sda_oe(sda_oe),
	.ref_is_external(ref_is_external),
	.ref_switch_quiet(ref_switch_quiet),
	.pll_shutdown(pll_shutdown),
	.out_mode(out_mode),
	.div_sync_reset(div_sync_reset),
	.config_ready(config_ready),
	.otp_busy(otp_busy)
);

/* i2c_master_model.sv */
// Purpose: Behavioural serial bus master facing the control block.
// Assumes: SDA has a pull-up; callers enter tasks at a clk_sys falling edge.
// Notes: SCL stands high between frames; half period 80 ns.
`timescale 1ns/1ps
module i2c_master_model (
	output logic scl,
	output logic sda_m,
	input wire logic sda_wire
);
	// Half of the 160 ns link period, a whole number of system cycles.
	localparam time HALF = 80ns;
	// Both lines released while idle.
	initial
	begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// Start or repeated start; the first wait lets an ack be released.
	task automatic start_cond();
		sda_m = 1'b1;
		#HALF scl = 1'b1;
		#HALF sda_m = 0;
		#HALF scl = 1'b0;
	endtask : start_cond
	// Stop leaves both lines high.
	task automatic stop_cond();
		sda_m = 1'b0;
		#HALF scl = 1'b1;
		#HALF sda_m = 1'b1;
		#HALF;
	endtask : stop_cond
	// Send a byte most significant bit first, then read the ack.
	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_m = d[i];
			#HALF scl = 1'b1;
			#HALF scl = 1'b0;
		end
		sda_m = 1'b1;
		#HALF scl = 1'b1;
		ack = !sda_wire;
		#HALF scl = 1'b0;
	endtask : wbyte
	// Receive a byte, then ack it or end the read with a nack.
	task automatic rbyte(input logic nack, output logic [7:0] d);
		sda_m = 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			#HALF scl = 1'b1;
			d = {d[6:0], sda_wire};
			#HALF scl = 1'b0;
		end
		sda_m = nack;
		#HALF scl = 1'b1;
		#HALF scl = 1'b0;
	endtask : rbyte
endmodule : i2c_master_model

/* clock_gen_config_control_tb.sv */
// Purpose: Self-checking bench of the clock generator control.
// Assumes: Serial strap mode, blank store, short sync pulse.
// Notes: Inputs change at clk_sys falling edges only.
`timescale 1ns/1ps
`include "cg_ctl_regs.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module clock_gen_config_control_tb
	import cg_ctl_pkg::*;
();
	typedef struct packed {logic [7:0] g; logic [7:0] r; logic sel; logic pin;
		logic [3:0] m0; logic ext;} row_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic sel_pin = 1'b0;
	logic gate_pin = 1'b0;
	wire scl;
	wire sda_m;
	logic sda_oe, ref_ext, quiet, manual, shut, sync_rst, ready, busy;
	out_mode_t [`NOUT-1:0] out_mode;
	logic [`NOUT-1:0][11:0] div_int;
	logic [`NOUT-1:0][23:0] div_frac;
	logic [`NOUT-1:0] int_only;
	logic [`NOUT-1:0][4:0] skew;
	logic [7:0] b0, b1;
	logic ack_bit; // Acks of the address part of the read frame.
	int n_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	// Gate polarity, function, primary source, pins and expected results.
	row_t tbl [5] = '{'{8'h00, 8'h00, 1'b0, 1'b1, 4'h1, 1'b0},
		'{8'h00, 8'h00, 1'b1, 1'b0, 4'h4, 1'b1}, '{8'h02, 8'h02, 1'b1, 1'b0, 4'h1, 1'b0},
		'{8'h02, 8'h02, 1'b0, 1'b1, 4'h4, 1'b1}, '{8'h0a, 8'h00, 1'b0, 1'b1, 4'h8, 1'b0}};
	always #10 clk_sys = ~clk_sys;
	// Open-drain data wire: either party may pull it low.
	i2c_master_model m (.scl(scl), .sda_m(sda_m), .sda_wire(sda_m & !sda_oe));
	// Short sync pulse keeps the run brief; strap and configuration select pins held low.
	clock_gen_config_control #(.SYNC_RST_CYCLES(20)) dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_m & !sda_oe), .sda_out(),
		.sda_oe(sda_oe), .input_select_pin(sel_pin), .shutdown_or_gate_pin(gate_pin),
		.config_select_pin_lo(1'b0), .config_select_pin_hi(1'b0),
		.interface_strap_pin(1'b0), .ref_is_external(ref_ext), .ref_switch_quiet(quiet),
		.manual_mode(manual), .pll_shutdown(shut), .out_mode(out_mode),
		.div_sync_reset(sync_rst), .div_int(div_int), .div_frac(div_frac),
		.div_int_only(int_only), .skew_step(skew), .config_ready(ready), .otp_busy(busy));
	// Print counts and verdict, then end the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish
	// A hang counts as a mismatch.
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	// Block write from register r; the stop may be left to the caller.
	task automatic wr_regs(input logic [7:0] r, input logic [7:0] d [$], input logic stp);
		logic a;
		m.start_cond();
		m.wbyte({`SLV_ADDR_DEF, 1'b0}, a);
		m.wbyte(8'h00, a);
		m.wbyte(r, a);
		foreach (d[i])
		begin
			m.wbyte(d[i], a);
			`CHK(a, 1'b1)
		end
		if (stp)
		begin
			m.stop_cond();
			repeat (12) @(negedge clk_sys);
		end
	endtask : wr_regs
	// Address-only frame; checks whether the device acknowledges.
	task automatic probe(input logic [6:0] dev, input logic exp);
		logic a;
		m.start_cond();
		m.wbyte({dev, 1'b0}, a);
		m.stop_cond();
		`CHK(a, exp)
	endtask : probe
	// Store command: address with write, one command byte, stop.
	task automatic cmd(input logic [7:0] c);
		logic a;
		m.start_cond();
		m.wbyte({`SLV_ADDR_DEF, 1'b0}, a);
		m.wbyte(c, a);
		m.stop_cond();
		repeat (10) @(negedge clk_sys);
	endtask : cmd
	// Bounded wait for the serial port to answer again.
	task automatic wait_ready();
		for (int i = 0; i < 800 && ready !== 1'b1; i++)
			@(negedge clk_sys);
		`CHK(ready, 1'b1)
	endtask : wait_ready
	// Main sequence.
	initial
	begin
		repeat (4) @(negedge clk_sys);
		sys_rst = 1'b0;
		probe(`SLV_ADDR_DEF, 1'b0);
		wait_ready();
		repeat (2) @(negedge clk_sys);
		`CHK(sync_rst, 1'b1)
		`CHK(out_mode[0], OM_TRI)
		`CHK(manual, 1'b1)
		$display("test start_up finished");
		wr_regs(8'h2d, '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hf9}, 1'b0);
		`CHK(div_int[0], 12'h000)
		m.stop_cond();
		repeat (12) @(negedge clk_sys);
		`CHK(div_int[0], 12'h234)
		`CHK(div_frac[0], 24'h56789a)
		`CHK(int_only[0], 1'b1)
		`CHK(skew[0], 5'h1f)
		m.start_cond();
		m.wbyte({`SLV_ADDR_DEF, 1'b0}, ack_bit);
		m.wbyte(8'h00, ack_bit);
		m.wbyte(8'h2d, ack_bit);
		m.start_cond();
		m.wbyte({`SLV_ADDR_DEF, 1'b1}, ack_bit);
		m.rbyte(1'b0, b0);
		m.rbyte(1'b1, b1);
		m.stop_cond();
		`CHK({b0, b1}, 16'h1234)
		$display("test block_access finished");
		wr_regs(8'h68, '{8'h11}, 1'b1);
		foreach (tbl[i])
		begin
			wr_regs(8'h10, '{tbl[i].g, 8'h00, 8'h00, tbl[i].r}, 1'b1);
			sel_pin = tbl[i].sel;
			gate_pin = tbl[i].pin;
			repeat (40) @(negedge clk_sys);
			`CHK(out_mode[0], tbl[i].m0)
			`CHK(out_mode[1], (tbl[i].m0 == 4'h8) ? 4'h8 : 4'h2)
			`CHK(shut, tbl[i].m0 == 4'h8)
			`CHK(ref_ext, tbl[i].ext)
		end
		$display("test pins_and_gating finished");
		wr_regs(8'h72, '{8'h20}, 1'b0);
		m.stop_cond();
		for (int i = 0; i < 50 && sync_rst !== 1'b1; i++)
			@(negedge clk_sys);
		`CHK(sync_rst, 1'b1)
		repeat (40) @(negedge clk_sys);
		cmd(`CMD_SAVE);
		probe(`SLV_ADDR_DEF, 1'b0);
		wait_ready();
		wr_regs(8'h2d, '{8'h00, 8'h00}, 1'b1);
		`CHK(div_int[0], 12'h000)
		cmd(`CMD_RESTORE);
		wait_ready();
		`CHK(div_int[0], 12'h234)
		$display("test store_and_sync finished");
		wr_regs(8'h00, '{8'h01}, 1'b1);
		probe(`SLV_ADDR_DEF, 1'b0);
		probe(`SLV_ADDR_ALT, 1'b1);
		$display("test address_select finished");
		tally_and_finish();
	end
endmodule : clock_gen_config_control_tb
